// *** src/aesc_enc_dev.sv ***
// encryption engine end: key expansion and ten-round block encryption
//
// Behaviour
// - each block encrypted alone, no chaining
// - key and blocks fixed at 128 bits
// - user loads a key before any block
// - key sampled when key-valid seen high
// - key setting lasts 10 cycles, busy falls
// - key busy high from acceptance to end
// - key busy ignores key and block requests
// - key done pulses in last setting cycle
// - loaded key kept until next key load
// - block sampled when block-valid seen high
// - encrypt busy rises next cycle, lasts 10
// - encrypt busy ignores block and key requests
// - encrypt done pulses in last cycle
// - result and result valid at finish
// - constant 11 cycles per block
// - user chains next block off done pulse
// - low reset returns engine to idle
// - everything on one system clock
`timescale 1ns/1ns
module aesc_enc_dev
(
    input  wire logic   clk,
    input  wire logic   resetn,
    aesc_if.dev         bus
);
    typedef enum logic [1:0] {AESC_IDLE, AESC_KEY, AESC_ENC} aesc_state_e;

    function automatic logic [7:0] aesc_gmul(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] p;
        logic [7:0] x;
        p = 8'h00;
        x = a;
        for (int i = 0; i < 8; i++)
        begin
            if (b[i])
                p = p ^ x;
            x = {x[6:0], 1'b0} ^ (x[7] ? aesc_pkg::AESC_GF_POLY : 8'h00);
        end
        return p;
    endfunction

    // multiplicative inverse as x^254, then the affine map
    function automatic logic [7:0] aesc_sbox(input logic [7:0] a);
        logic [7:0] t;
        logic [7:0] inv;
        t   = a;
        inv = aesc_pkg::AESC_GF_ONE;
        for (int i = 1; i < 8; i++)
        begin
            t   = aesc_gmul(t, t);
            inv = aesc_gmul(inv, t);
        end
        return inv ^ {inv[6:0], inv[7]} ^ {inv[5:0], inv[7:6]} ^ {inv[4:0], inv[7:5]}
               ^ {inv[3:0], inv[7:4]} ^ aesc_pkg::AESC_AFFINE_C;
    endfunction

    function automatic logic [31:0] aesc_subword(input logic [31:0] w);
        return {aesc_sbox(w[31:24]), aesc_sbox(w[23:16]), aesc_sbox(w[15:8]),
                aesc_sbox(w[7:0])};
    endfunction

    function automatic aesc_pkg::aesc_blk_t aesc_expand(input aesc_pkg::aesc_blk_t k,
                                                        input logic [7:0] rcon);
        logic [31:0] tmp;
        logic [31:0] n0;
        logic [31:0] n1;
        logic [31:0] n2;
        logic [31:0] n3;
        tmp = aesc_subword({k[23:0], k[31:24]}) ^ {rcon, 24'h000000};
        n0  = k[127:96] ^ tmp;
        n1  = k[95:64] ^ n0;
        n2  = k[63:32] ^ n1;
        n3  = k[31:0] ^ n2;
        return {n0, n1, n2, n3};
    endfunction

    // byte i sits at [127-8i]; bytes 4c..4c+3 form column c
    function automatic aesc_pkg::aesc_blk_t aesc_round(input aesc_pkg::aesc_blk_t s,
                                                       input aesc_pkg::aesc_blk_t rk,
                                                       input logic last);
        logic [7:0]          b[16];
        logic [7:0]          m[16];
        aesc_pkg::aesc_blk_t o;
        o = '0;
        for (int i = 0; i < 16; i++)
            b[i] = aesc_sbox(s[127-8*i -: 8]);
        for (int c = 0; c < 4; c++)
            for (int r = 0; r < 4; r++)
                m[r+4*c] = b[r+4*((c+r)%4)];
        for (int c = 0; c < 4; c++)
            for (int r = 0; r < 4; r++)
                o[127-8*(4*c+r) -: 8] = last ? m[4*c+r] :
                    aesc_gmul(m[4*c+r], aesc_pkg::AESC_GF_X)
                    ^ aesc_gmul(m[4*c+(r+1)%4], aesc_pkg::AESC_GF_X) ^ m[4*c+(r+1)%4]
                    ^ m[4*c+(r+2)%4] ^ m[4*c+(r+3)%4];
        return o ^ rk;
    endfunction

    aesc_state_e          state_q;
    logic [3:0]           rnd_q;
    logic [7:0]           rcon_q;
    aesc_pkg::aesc_blk_t  work_q;
    aesc_pkg::aesc_blk_t  st_q;
    aesc_pkg::aesc_blk_t  rk_q[aesc_pkg::AESC_NUM_RK];
    logic                 key_busy_q;
    logic                 key_done_q;
    logic                 enc_busy_q;
    logic                 enc_done_q;
    logic                 res_valid_q;
    aesc_pkg::aesc_blk_t  res_block_q;

    wire                  idle      = (state_q == AESC_IDLE);
    // requests count only while idle; key wins a tie
    wire                  take_key  = idle && bus.key_load_valid;
    wire                  take_blk  = idle && !bus.key_load_valid && bus.plain_valid;
    wire                  rnd_last  = (rnd_q == aesc_pkg::AESC_RND_LAST);
    wire                  rnd_pre   = (rnd_q == aesc_pkg::AESC_RND_PRE);
    wire aesc_pkg::aesc_blk_t key_next = aesc_expand(work_q, rcon_q);
    wire aesc_pkg::aesc_blk_t rnd_out  = aesc_round(st_q, rk_q[rnd_q], rnd_last);
    wire aesc_pkg::aesc_blk_t pre_add  = bus.plain_block ^ rk_q[0];
    wire [7:0]            rcon_next = aesc_gmul(rcon_q, aesc_pkg::AESC_GF_X);
    wire [3:0]            rnd_inc   = rnd_q + aesc_pkg::AESC_RND_FIRST;

    // round key store, kept across blocks until the next load
    always_ff @(posedge clk)
    begin
        if (take_key)
            rk_q[0] <= bus.key_word;
        else if (state_q == AESC_KEY)
            rk_q[rnd_q] <= key_next;
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            state_q     <= AESC_IDLE;
            rnd_q       <= aesc_pkg::AESC_RND_ZERO;
            rcon_q      <= aesc_pkg::AESC_RCON_INIT;
            work_q      <= '0;
            st_q        <= '0;
            key_busy_q  <= 1'b0;
            key_done_q  <= 1'b0;
            enc_busy_q  <= 1'b0;
            enc_done_q  <= 1'b0;
            res_valid_q <= 1'b0;
            res_block_q <= '0;
        end
        else
        begin
            key_done_q  <= 1'b0;
            enc_done_q  <= 1'b0;
            res_valid_q <= 1'b0;
            case (state_q)
                AESC_IDLE:
                begin
                    rnd_q <= aesc_pkg::AESC_RND_FIRST;
                    if (take_key)
                    begin
                        work_q     <= bus.key_word;
                        rcon_q     <= aesc_pkg::AESC_RCON_INIT;
                        key_busy_q <= 1'b1;
                        state_q    <= AESC_KEY;
                    end
                    else if (take_blk)
                    begin
                        st_q       <= pre_add;
                        enc_busy_q <= 1'b1;
                        state_q    <= AESC_ENC;
                    end
                end
                AESC_KEY:
                begin
                    work_q     <= key_next;
                    rcon_q     <= rcon_next;
                    rnd_q      <= rnd_inc;
                    key_done_q <= rnd_pre;
                    if (rnd_last)
                    begin
                        key_busy_q <= 1'b0;
                        state_q    <= AESC_IDLE;
                    end
                end
                AESC_ENC:
                begin
                    st_q       <= rnd_out;
                    rnd_q      <= rnd_inc;
                    enc_done_q <= rnd_pre;
                    if (rnd_last)
                    begin
                        enc_busy_q  <= 1'b0;
                        res_valid_q <= 1'b1;
                        res_block_q <= rnd_out;
                        state_q     <= AESC_IDLE;
                    end
                end
                default:
                begin
                    state_q    <= AESC_IDLE;
                    key_busy_q <= 1'b0;
                    enc_busy_q <= 1'b0;
                end
            endcase
        end
    end

    assign bus.key_load_busy = key_busy_q;
    assign bus.key_load_done = key_done_q;
    assign bus.encrypt_busy  = enc_busy_q;
    assign bus.encrypt_done  = enc_done_q;
    assign bus.result_valid  = res_valid_q;
    assign bus.result_block  = res_block_q;
endmodule

// *** shared/aesc_pkg.sv ***
// constants shared by both ends of the block encryption engine
package aesc_pkg;
    localparam int          AESC_BLK_W      = 128;
    localparam int          AESC_NUM_RK     = 11;
    localparam int          AESC_KEY_CYCLES = 10;
    localparam int          AESC_ENC_CYCLES = 10;
    localparam logic [3:0]  AESC_RND_FIRST  = 4'h1;
    localparam logic [3:0]  AESC_RND_LAST   = 4'hA;
    localparam logic [3:0]  AESC_RND_PRE    = 4'h9;
    localparam logic [3:0]  AESC_RND_ZERO   = 4'h0;
    localparam logic [7:0]  AESC_RCON_INIT  = 8'h01;
    localparam logic [7:0]  AESC_GF_POLY    = 8'h1B;
    localparam logic [7:0]  AESC_GF_X       = 8'h02;
    localparam logic [7:0]  AESC_GF_ONE     = 8'h01;
    localparam logic [7:0]  AESC_AFFINE_C   = 8'h63;
    localparam int          AESC_FIFO_W     = 128;
    localparam int          AESC_FIFO_DEPTH = 32;
    typedef logic [AESC_BLK_W-1:0] aesc_blk_t;
endpackage

// *** shared/aesc_if.sv ***
// handshake signals between the encryption engine and its user logic
`timescale 1ns/1ns
interface aesc_if;
    logic                  key_load_valid;
    aesc_pkg::aesc_blk_t   key_word;
    logic                  key_load_busy;
    logic                  key_load_done;
    logic                  plain_valid;
    aesc_pkg::aesc_blk_t   plain_block;
    logic                  encrypt_busy;
    logic                  encrypt_done;
    logic                  result_valid;
    aesc_pkg::aesc_blk_t   result_block;

    modport dev
    (
        input  key_load_valid, key_word, plain_valid, plain_block,
        output key_load_busy, key_load_done, encrypt_busy, encrypt_done,
        output result_valid, result_block
    );

    modport usr
    (
        output key_load_valid, key_word, plain_valid, plain_block,
        input  key_load_busy, key_load_done, encrypt_busy, encrypt_done,
        input  result_valid, result_block
    );
endinterface

// *** src/aesc_enc_usr.sv ***
// user end: plaintext queue, key issue and block issue toward the engine
`timescale 1ns/1ns
module aesc_fifo
#(
    parameter int W     = aesc_pkg::AESC_FIFO_W,
    parameter int DEPTH = aesc_pkg::AESC_FIFO_DEPTH
)
(
    input  wire logic           clk,
    input  wire logic           resetn,
    input  wire logic           in_valid,
    output logic                in_ready,
    input  wire logic [W-1:0]   in_data,
    output logic                out_valid,
    input  wire logic           out_ready,
    output logic [W-1:0]        out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0]   mem[DEPTH];
    logic [AW-1:0]  wr_q;
    logic [AW-1:0]  rd_q;
    logic [AW:0]    cnt_q;
    logic           rdy_q;

    wire            push  = in_valid && rdy_q;
    wire            pop   = out_ready && (cnt_q != '0);
    wire [AW:0]     cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);

    always_ff @(posedge clk)
    begin
        if (push)
            mem[wr_q] <= in_data;
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
            rdy_q <= 1'b0;
        end
        else
        begin
            wr_q  <= wr_q + AW'(push);
            rd_q  <= rd_q + AW'(pop);
            cnt_q <= cnt_d;
            rdy_q <= (cnt_d != (AW+1)'(DEPTH));
        end
    end

    assign in_ready  = rdy_q;
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem[rd_q];
endmodule

module aesc_enc_usr
(
    input  wire logic                   clk,
    input  wire logic                   resetn,
    aesc_if.usr                         bus,
    input  wire logic                   key_in_valid,
    input  wire aesc_pkg::aesc_blk_t    key_in,
    output logic                        key_in_busy,
    output logic                        key_ready,
    input  wire logic                   blk_in_valid,
    input  wire aesc_pkg::aesc_blk_t    blk_in,
    output logic                        blk_in_ready,
    output logic                        blk_out_valid,
    output aesc_pkg::aesc_blk_t         blk_out
);
    logic                  key_pend_q;
    aesc_pkg::aesc_blk_t   key_hold_q;
    logic                  key_loaded_q;
    logic                  kv_q;
    aesc_pkg::aesc_blk_t   kw_q;
    logic                  pv_q;
    aesc_pkg::aesc_blk_t   pb_q;
    logic                  ov_q;
    aesc_pkg::aesc_blk_t   ob_q;
    logic                  q_valid;
    aesc_pkg::aesc_blk_t   q_data;
    logic                  q_in_ready;

    // free now, or in the engine's last cycle so the next request lands back to back
    wire    eng_free = (!bus.key_load_busy && !bus.encrypt_busy && !kv_q && !pv_q)
                       || bus.encrypt_done || bus.key_load_done;
    wire    key_go   = eng_free && key_pend_q;
    wire    blk_go   = eng_free && !key_pend_q && key_loaded_q && q_valid;
    wire    key_take = key_in_valid && !key_pend_q;

    aesc_fifo
    #(
        .W      (aesc_pkg::AESC_FIFO_W),
        .DEPTH  (aesc_pkg::AESC_FIFO_DEPTH)
    )
    u_queue
    (
        .clk        (clk),
        .resetn     (resetn),
        .in_valid   (blk_in_valid),
        .in_ready   (q_in_ready),
        .in_data    (blk_in),
        .out_valid  (q_valid),
        .out_ready  (blk_go),
        .out_data   (q_data)
    );

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            key_pend_q   <= 1'b0;
            key_hold_q   <= '0;
            key_loaded_q <= 1'b0;
            kv_q         <= 1'b0;
            kw_q         <= '0;
            pv_q         <= 1'b0;
            pb_q         <= '0;
            ov_q         <= 1'b0;
            ob_q         <= '0;
        end
        else
        begin
            if (key_take)
            begin
                key_pend_q <= 1'b1;
                key_hold_q <= key_in;
            end
            else if (key_go)
                key_pend_q <= 1'b0;
            if (key_go)
                key_loaded_q <= 1'b0;
            else if (bus.key_load_done)
                key_loaded_q <= 1'b1;
            kv_q <= key_go;
            if (key_go)
                kw_q <= key_hold_q;
            pv_q <= blk_go;
            if (blk_go)
                pb_q <= q_data;
            ov_q <= bus.result_valid;
            if (bus.result_valid)
                ob_q <= bus.result_block;
        end
    end

    assign bus.key_load_valid = kv_q;
    assign bus.key_word       = kw_q;
    assign bus.plain_valid    = pv_q;
    assign bus.plain_block    = pb_q;
    assign key_in_busy        = key_pend_q;
    assign key_ready          = key_loaded_q;
    assign blk_in_ready       = q_in_ready;
    assign blk_out_valid      = ov_q;
    assign blk_out            = ob_q;
endmodule

// *** tb/aesc_chk.sv ***
// timing checker for the engine handshake between the two ends
`timescale 1ns/1ns
module aesc_chk
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic key_load_valid,
    input wire logic key_load_busy,
    input wire logic key_load_done,
    input wire logic plain_valid,
    input wire logic encrypt_busy,
    input wire logic encrypt_done,
    input wire logic result_valid
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    wire idle   = !key_load_busy && !encrypt_busy;
    wire key_go = key_load_valid && idle;
    wire blk_go = plain_valid && !key_load_valid && idle;

    property p_key_busy;
        key_go |=> key_load_busy[*5] ##1 key_load_busy[*5] ##1 !key_load_busy;
    endproperty
    a_key_busy: assert property (p_key_busy) else $error("key busy length wrong");
    property p_key_done;
        key_go |-> ##10 key_load_done ##1 !key_load_done;
    endproperty
    a_key_done: assert property (p_key_done) else $error("key done misplaced");
    property p_key_last;
        key_load_done |-> key_load_busy ##1 !key_load_busy;
    endproperty
    a_key_last: assert property (p_key_last) else $error("key done not last");
    property p_key_excl;
        $rose(key_load_busy) |-> $past(key_go);
    endproperty
    a_key_excl: assert property (p_key_excl) else $error("key taken while busy");
    property p_enc_excl;
        $rose(encrypt_busy) |-> $past(blk_go);
    endproperty
    a_enc_excl: assert property (p_enc_excl) else $error("block taken while busy");
    property p_enc_busy;
        blk_go |=> encrypt_busy[*5] ##1 encrypt_busy[*5] ##1 !encrypt_busy;
    endproperty
    a_enc_busy: assert property (p_enc_busy) else $error("encrypt busy length wrong");
    property p_enc_done;
        blk_go |-> ##10 encrypt_done && encrypt_busy ##1 !encrypt_done;
    endproperty
    a_enc_done: assert property (p_enc_done) else $error("encrypt done misplaced");
    property p_result;
        blk_go |-> ##11 result_valid;
    endproperty
    a_result: assert property (p_result) else $error("result not at cycle 11");
    property p_result_src;
        result_valid |-> $past(encrypt_done);
    endproperty
    a_result_src: assert property (p_result_src) else $error("result without done");
    property p_quiet;
        disable iff (1'b0)
        !resetn |=> !(key_load_busy || encrypt_busy || key_load_done || encrypt_done
                      || result_valid);
    endproperty
    a_quiet: assert property (p_quiet) else $error("status high after reset");
endmodule

// *** tb/aes_ecb_encrypt_core_test.sv ***
// self-checking bench: user end and engine end joined through the interface
`timescale 1ns/1ns
module aes_ecb_encrypt_core_test;
    logic                clk;
    logic                resetn;
    logic                key_in_valid;
    aesc_pkg::aesc_blk_t key_in;
    logic                key_in_busy;
    logic                key_ready;
    logic                blk_in_valid;
    aesc_pkg::aesc_blk_t blk_in;
    logic                blk_in_ready;
    logic                blk_out_valid;
    aesc_pkg::aesc_blk_t blk_out;
    aesc_pkg::aesc_blk_t key_m;
    aesc_pkg::aesc_blk_t exp_q[$];
    logic [7:0]          sbox[256];
    int                  fail_count;
    int                  n_tests;
    int                  cyc;
    int                  full_seen;
    int                  last_out;
    bit                  chain_on;

    // result spacing when blocks are queued back to back
    localparam int       CADENCE = aesc_pkg::AESC_ENC_CYCLES + 1;

    aesc_if bus_if ();
    aesc_enc_dev aesc_enc_dev_i (.clk(clk), .resetn(resetn), .bus(bus_if.dev));
    aesc_enc_usr aesc_enc_usr_i (.clk(clk), .resetn(resetn), .bus(bus_if.usr),
        .key_in_valid(key_in_valid), .key_in(key_in), .key_in_busy(key_in_busy),
        .key_ready(key_ready), .blk_in_valid(blk_in_valid), .blk_in(blk_in),
        .blk_in_ready(blk_in_ready), .blk_out_valid(blk_out_valid), .blk_out(blk_out));
    aesc_chk aesc_chk_i (.clk(clk), .resetn(resetn), .key_load_valid(bus_if.key_load_valid),
        .key_load_busy(bus_if.key_load_busy), .key_load_done(bus_if.key_load_done),
        .plain_valid(bus_if.plain_valid), .encrypt_busy(bus_if.encrypt_busy),
        .encrypt_done(bus_if.encrypt_done), .result_valid(bus_if.result_valid));

    always #10 clk = ~clk;

    function automatic logic [7:0] mul(logic [7:0] a, logic [7:0] b);
        logic [7:0] p;
        p = 8'h00;
        for (int i = 0; i < 8; i++)
        begin
            if (b[i])
                p = p ^ a;
            a = {a[6:0], 1'b0} ^ (a[7] ? aesc_pkg::AESC_GF_POLY : 8'h00);
        end
        return p;
    endfunction

    // reference cipher, state byte i = row i%4, column i/4
    function automatic aesc_pkg::aesc_blk_t enc(aesc_pkg::aesc_blk_t k, aesc_pkg::aesc_blk_t p);
        logic [7:0] s[16];
        logic [7:0] t[16];
        logic [7:0] w[16];
        logic [7:0] rc;
        rc = 8'h01;
        for (int i = 0; i < 16; i++)
        begin
            w[i] = k[127-8*i -: 8];
            s[i] = p[127-8*i -: 8] ^ w[i];
        end
        for (int r = 1; r <= 10; r++)
        begin
            w[0] = w[0] ^ sbox[w[13]] ^ rc;
            w[1] = w[1] ^ sbox[w[14]];
            w[2] = w[2] ^ sbox[w[15]];
            w[3] = w[3] ^ sbox[w[12]];
            for (int i = 4; i < 16; i++)
                w[i] = w[i] ^ w[i-4];
            for (int i = 0; i < 16; i++)
                t[i] = sbox[s[(i + 4 * (i % 4)) % 16]];
            for (int i = 0; i < 16; i++)
                s[i] = w[i] ^ ((r == 10) ? t[i] : mul(t[i], 8'h02)
                     ^ mul(t[(i & 12) + (i + 1) % 4], 8'h03)
                     ^ t[(i & 12) + (i + 2) % 4] ^ t[(i & 12) + (i + 3) % 4]);
            rc = mul(rc, 8'h02);
        end
        for (int i = 0; i < 16; i++)
            p[127-8*i -: 8] = s[i];
        return p;
    endfunction

    function automatic aesc_pkg::aesc_blk_t rnd();
        return {$urandom, $urandom, $urandom, $urandom};
    endfunction

    task automatic check_blk(string name, aesc_pkg::aesc_blk_t e, aesc_pkg::aesc_blk_t g);
        n_tests++;
        if (e !== g)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic check_bit(string name, logic e, logic g);
        n_tests++;
        if (e !== g)
        begin
            fail_count++;
            $display("wrong value %s expected %b seen %b", name, e, g);
        end
    endtask

    task automatic end_sim();
        if (fail_count == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic tick();
        @(posedge clk);
        #1;
    endtask

    // leaves valid high so pushes can run back to back
    task automatic push(aesc_pkg::aesc_blk_t b);
        while (blk_in_ready !== 1'b1)
        begin
            blk_in_valid = 0;
            tick();
        end
        blk_in_valid = 1;
        blk_in = b;
        exp_q.push_back(enc(key_m, b));
        tick();
    endtask

    task automatic idle(int n);
        blk_in_valid = 0;
        repeat (n + 1) tick();
    endtask

    task automatic load_key(aesc_pkg::aesc_blk_t k);
        while (key_in_busy !== 1'b0) tick();
        key_in_valid = 1;
        key_in = k;
        tick();
        check_bit("key_in_busy", 1'b1, key_in_busy);
        key_in_valid = 0;
        key_m = k;
        repeat (3) tick();
        check_bit("key_ready", 1'b0, key_ready);
        while (key_ready !== 1'b1) tick();
    endtask

    task automatic drain();
        int n;
        n = 0;
        while (exp_q.size() != 0 && n < (aesc_pkg::AESC_FIFO_DEPTH + 8) * CADENCE)
        begin
            tick();
            n++;
        end
        check_bit("drained", 1'b1, logic'(exp_q.size() == 0));
    endtask

    always @(posedge clk)
    begin
        cyc++;
        if (blk_in_ready === 1'b0)
            full_seen++;
        if (blk_out_valid === 1'b1)
        begin
            if (chain_on && last_out > 0)
                check_bit("cadence", 1'b1, logic'(cyc - last_out == CADENCE));
            last_out = cyc;
            check_blk("cipher", exp_q.size() ? exp_q.pop_front() : 'x, blk_out);
        end
        if (cyc == 20000)
        begin
            fail_count++;
            end_sim();
        end
    end

    initial
    begin
        logic [7:0] y;
        clk = 0;
        resetn = 0;
        key_in_valid = 0;
        key_in = '0;
        blk_in_valid = 0;
        blk_in = '0;
        fail_count = 0;
        n_tests = 0;
        cyc = 0;
        void'($urandom(32'h7414));
        for (int x = 0; x < 256; x++)
        begin
            y = 8'h01;
            repeat (254) y = mul(y, x[7:0]);
            sbox[x] = y ^ {y[6:0], y[7]} ^ {y[5:0], y[7:6]} ^ {y[4:0], y[7:5]}
                    ^ {y[3:0], y[7:4]} ^ aesc_pkg::AESC_AFFINE_C;
        end
        check_blk("model", 128'h69C4E0D86A7B0430D8CDB78070B4C55A,
            enc(128'h000102030405060708090A0B0C0D0E0F, 128'h00112233445566778899AABBCCDDEEFF));
        repeat (2) tick();
        resetn = 1;
        load_key(128'h000102030405060708090A0B0C0D0E0F);
        chain_on = 1;
        push(128'h00112233445566778899AABBCCDDEEFF);
        push('0);
        push('1);
        push('1);
        full_seen = 0;
        repeat (40) push(rnd());
        check_bit("fifo full", 1'b1, logic'(full_seen > 0));
        idle(0);
        drain();
        chain_on = 0;
        load_key(rnd());
        repeat (20)
        begin
            push(rnd());
            idle($urandom_range(0, 12));
        end
        drain();
        repeat (5) push(rnd());
        idle(30);
        resetn = 0;
        repeat (2) tick();
        check_bit("key_ready", 1'b0, key_ready);
        check_bit("key_in_busy", 1'b0, key_in_busy);
        check_bit("blk_in_ready", 1'b0, blk_in_ready);
        check_bit("blk_out_valid", 1'b0, blk_out_valid);
        exp_q.delete();
        resetn = 1;
        // block queued before any key: must wait for the load
        key_m = rnd();
        push(rnd());
        idle(0);
        load_key(key_m);
        push(rnd());
        idle(0);
        drain();
        end_sim();
    end
endmodule
